// ===== hdl/bfc_top.sv
// bfc_top: bridge forwarding control registers and policy outputs
// assumes: config cycles already decoded to type 0 read/write strobes
// Operation
// - legacy display on: claim primary memory A0000-BFFFF and forward down
// - legacy display on: forward primary VGA I/O ranges, upper half zero
// - legacy display off: ignore it unless inside I/O window, filter clear
// - legacy display on: never claim those transactions on secondary bus
// - legacy forwarding needs both I/O and memory space enables
// - alias filter clear: forward all primary I/O inside window
// - alias filter set: drop window I/O in 64KB at top 768B of 1KB
// - alias filter set: forward secondary I/O at top 768B of 1KB upstream
// - forwarding and driver enable set: downstream system error drives upstream
// - forwarding off: downstream system error never drives upstream line
// - parity response clear: no downstream parity error, no status, no report
// - parity response set: drive parity error and set reported status bit
// - secondary address parity reports upstream only with parity response set
// - device specific registers start at 0x40, optional for software
// - chip reset bit resets everything and self clears when done
// - chip reset also sets secondary reset bit; held until software clears
// - prefetch disable clear: prefetch upstream reads, no byte enables forwarded
// - prefetch disable set: plain reads one dword, disconnect on first data
// - write disconnect clear: disconnect only on queue full or 4KB
// - write disconnect set: also disconnect at each cache line boundary
// - chip control reserved bits read as zero
// - secondary reset clears buffers and secondary side, config kept
module bfc_top
	import bfc_pkg::*;
#(
	parameter int CHIP_RST_CYC = BFC_CHIP_RST_CYC
)
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic cfg_rd,
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_addr,
	input wire logic [3:0] upstream_cmd_byte_en_n,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_ack,
	input wire logic [31:0] io_base,
	input wire logic [31:0] io_limit,
	input wire logic [31:0] txn_addr,
	input wire logic txn_io,
	input wire logic txn_mem,
	input wire logic txn_primary,
	output logic txn_claim,
	input wire logic downstream_system_error_n,
	input wire logic sec_data_parity_err,
	input wire logic sec_addr_parity_err,
	input wire logic sec_status_clr,
	output logic upstream_system_error_n,
	output logic downstream_parity_error_n,
	output logic sec_parity_reported,
	input wire logic rd_plain,
	input wire logic wr_cacheline_edge,
	input wire logic wr_queue_full,
	input wire logic [31:0] wr_addr,
	output logic rd_prefetch,
	output logic rd_fwd_byte_en,
	output logic rd_disc_first,
	output logic wr_disconnect,
	output logic downstream_reset_n,
	output logic chip_reset_busy
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum logic [1:0] {BFC_RUN, BFC_CHIP_RST} bfc_st_t;
	typedef struct packed {
		bfc_st_t st;
		logic [7:0] cnt;
		logic [15:0] cmd;
		logic [7:0] bctl;
		logic [15:0] chip;
		logic [31:0] rdata;
		logic ack;
		logic claim;
		logic serr_n;
		logic perr_n;
		logic par_rep;
		logic pref;
		logic fwd_be;
		logic disc1;
		logic wdisc;
		logic srst_n;
		logic s_sync1;
		logic s_sync2;
		logic busy;
	} bfc_state_t;

	bfc_state_t st_r;
	bfc_state_t st_nxt;
	logic claim_c;

	function automatic logic [7:0] be_merge(input logic [7:0] old, input logic [7:0] nw,
		input logic en_n);
		be_merge = en_n ? old : nw;
	endfunction

	bfc_decode bfc_decode_i (
		.addr(txn_addr),
		.is_io(txn_io),
		.is_mem(txn_mem),
		.from_primary(txn_primary),
		.legacy_display_en(st_r.bctl[BFC_BIT_LEGACY_DISP - 16]),
		.legacy_io_alias_filter(st_r.bctl[BFC_BIT_ALIAS - 16]),
		.io_space_en(st_r.cmd[BFC_BIT_IO_EN]),
		.mem_space_en(st_r.cmd[BFC_BIT_MEM_EN]),
		.io_base(io_base),
		.io_limit(io_limit),
		.claim(claim_c)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		logic perr_on;
		logic serr_fwd;
		logic s_asserted;
		logic [15:0] chip_w;
		perr_on = 1'b0;
		serr_fwd = 1'b0;
		s_asserted = 1'b0;
		chip_w = '0;
		st_nxt = st_r;
		st_nxt.ack = 1'b0;
		st_nxt.s_sync1 = downstream_system_error_n;
		st_nxt.s_sync2 = st_r.s_sync1;
		st_nxt.claim = claim_c;
		perr_on = st_r.bctl[BFC_BIT_PARITY_RESP - 16];
		serr_fwd = st_r.bctl[BFC_BIT_SERR_FWD - 16];
		s_asserted = !st_r.s_sync2;
		// upstream system error
		st_nxt.serr_n = !(st_r.cmd[BFC_BIT_SERR_DRV]
			&& ((serr_fwd && s_asserted)
			|| (perr_on && sec_addr_parity_err)));
		st_nxt.perr_n = !(perr_on && sec_data_parity_err);
		// set wins over clear
		if (sec_status_clr)
			st_nxt.par_rep = 1'b0;
		if (perr_on && sec_data_parity_err)
			st_nxt.par_rep = 1'b1;
		// upstream read and write policy
		st_nxt.pref = !st_r.chip[BFC_BIT_PREF_DIS] || !rd_plain;
		st_nxt.fwd_be = st_r.chip[BFC_BIT_PREF_DIS] && rd_plain;
		st_nxt.disc1 = st_r.chip[BFC_BIT_PREF_DIS] && rd_plain;
		st_nxt.wdisc = wr_queue_full
			|| wr_addr[BFC_WRITE_DISC_4K_MASK - 1:0] == '0
			|| (st_r.chip[BFC_BIT_WR_DISC] && wr_cacheline_edge);
		st_nxt.srst_n = !st_r.bctl[BFC_BIT_SEC_RESET - 16];
		// register access
		if (cfg_rd && st_r.st == BFC_RUN)
		begin
			st_nxt.ack = 1'b1;
			case (cfg_addr)
				BFC_OFS_CMD: st_nxt.rdata = {16'h0000, st_r.cmd};
				BFC_OFS_BRIDGE_CTRL: st_nxt.rdata = {8'h00, st_r.bctl, 16'h0000};
				BFC_OFS_CHIP_CTRL: st_nxt.rdata = {16'h0000,
					st_r.chip & BFC_CHIP_CTRL_RMASK};
				default: st_nxt.rdata = 32'h00000000;
			endcase
		end
		else if (cfg_wr && st_r.st == BFC_RUN)
		begin
			st_nxt.ack = 1'b1;
			case (cfg_addr)
				BFC_OFS_CMD:
				begin
					st_nxt.cmd[7:0] = be_merge(st_r.cmd[7:0], cfg_wdata[7:0],
						upstream_cmd_byte_en_n[0]);
					st_nxt.cmd[15:8] = be_merge(st_r.cmd[15:8], cfg_wdata[15:8],
						upstream_cmd_byte_en_n[1]);
				end
				BFC_OFS_BRIDGE_CTRL:
				begin
					st_nxt.bctl = be_merge(st_r.bctl, cfg_wdata[23:16],
						upstream_cmd_byte_en_n[2]) & 8'h4F;
				end
				BFC_OFS_CHIP_CTRL:
				begin
					chip_w[7:0] = be_merge(st_r.chip[7:0], cfg_wdata[7:0],
						upstream_cmd_byte_en_n[0]);
					chip_w[15:8] = be_merge(st_r.chip[15:8], cfg_wdata[15:8],
						upstream_cmd_byte_en_n[1]);
					st_nxt.chip = chip_w & BFC_CHIP_CTRL_RMASK;
					if (chip_w[BFC_BIT_CHIP_RST])
					begin
						st_nxt.st = BFC_CHIP_RST;
						st_nxt.cnt = 8'(CHIP_RST_CYC);
					end
				end
				default:
				begin
				end
			endcase
		end
		// whole chip reset sequence
		case (st_r.st)
			BFC_RUN:
			begin
			end
			BFC_CHIP_RST:
			begin
				st_nxt.cmd = BFC_CMD_RST;
				st_nxt.bctl = 8'h00;
				st_nxt.bctl[BFC_BIT_SEC_RESET - 16] = 1'b1;
				st_nxt.par_rep = 1'b0;
				st_nxt.srst_n = 1'b0;
				st_nxt.cnt = st_r.cnt - 8'h01;
				if (st_r.cnt <= 8'h01)
				begin
					st_nxt.st = BFC_RUN;
					st_nxt.chip = BFC_CHIP_CTRL_RST;
				end
			end
			default: st_nxt.st = BFC_RUN;
		endcase
		st_nxt.busy = (st_nxt.st == BFC_CHIP_RST);
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			st_r <= '{st: BFC_RUN, cnt: 8'h00, cmd: BFC_CMD_RST, bctl: 8'h00,
				chip: BFC_CHIP_CTRL_RST, rdata: 32'h00000000, ack: 1'b0, claim: 1'b0,
				serr_n: 1'b1, perr_n: 1'b1, par_rep: 1'b0, pref: 1'b1, fwd_be: 1'b0,
				disc1: 1'b0, wdisc: 1'b0, srst_n: 1'b1, s_sync1: 1'b1, s_sync2: 1'b1,
				busy: 1'b0};
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign cfg_rdata = st_r.rdata;
	assign cfg_ack = st_r.ack;
	assign txn_claim = st_r.claim;
	assign upstream_system_error_n = st_r.serr_n;
	assign downstream_parity_error_n = st_r.perr_n;
	assign sec_parity_reported = st_r.par_rep;
	assign rd_prefetch = st_r.pref;
	assign rd_fwd_byte_en = st_r.fwd_be;
	assign rd_disc_first = st_r.disc1;
	assign wr_disconnect = st_r.wdisc;
	assign downstream_reset_n = st_r.srst_n;
	assign chip_reset_busy = st_r.busy;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	sequence s_chip_go;
		cfg_wr && !cfg_rd && cfg_addr == BFC_OFS_CHIP_CTRL && !upstream_cmd_byte_en_n[1]
			&& cfg_wdata[BFC_BIT_CHIP_RST] && st_r.st == BFC_RUN;
	endsequence
	sequence s_chip_done;
		##[1:300] (st_r.st == BFC_RUN && st_r.chip[BFC_BIT_CHIP_RST] == 1'b0);
	endsequence

	a_chip_reset_clears: assert property (s_chip_go |-> s_chip_done)
		else $error("chip reset bit did not self clear");
	a_chip_reset_srst: assert property (s_chip_go |=> ##1 !downstream_reset_n)
		else $error("chip reset did not assert downstream reset");
	a_serr_fwd_off: assert property (!st_r.bctl[BFC_BIT_SERR_FWD - 16]
		&& !(st_r.bctl[BFC_BIT_PARITY_RESP - 16] && sec_addr_parity_err)
		|=> upstream_system_error_n)
		else $error("upstream error driven with forwarding off");
	a_serr_fwd_on: assert property (st_r.bctl[BFC_BIT_SERR_FWD - 16]
		&& st_r.cmd[BFC_BIT_SERR_DRV] && !st_r.s_sync2 |=> !upstream_system_error_n)
		else $error("downstream error not forwarded");
	a_perr_gate: assert property (!st_r.bctl[BFC_BIT_PARITY_RESP - 16]
		|=> downstream_parity_error_n)
		else $error("parity error driven with response off");
	a_perr_drive: assert property (st_r.bctl[BFC_BIT_PARITY_RESP - 16]
		&& sec_data_parity_err |=> !downstream_parity_error_n && sec_parity_reported)
		else $error("parity error not reported");
	a_addr_par_gate: assert property (!st_r.bctl[BFC_BIT_PARITY_RESP - 16]
		&& !st_r.bctl[BFC_BIT_SERR_FWD - 16] |=> upstream_system_error_n)
		else $error("address parity reported without response bit");
	a_chip_reserved: assert property (cfg_ack && $past(cfg_rd)
		&& $past(cfg_addr) == BFC_OFS_CHIP_CTRL
		|-> (cfg_rdata & {16'hFFFF, ~BFC_CHIP_CTRL_RMASK}) == 32'h00000000)
		else $error("reserved chip control bits not zero");
	a_pref_plain: assert property (st_r.chip[BFC_BIT_PREF_DIS] && rd_plain
		|=> !rd_prefetch && rd_fwd_byte_en && rd_disc_first)
		else $error("plain read prefetched with prefetch disabled");
	a_pref_on: assert property (!st_r.chip[BFC_BIT_PREF_DIS]
		|=> rd_prefetch && !rd_fwd_byte_en)
		else $error("prefetch missing with disable clear");
	a_wdisc_line: assert property (st_r.chip[BFC_BIT_WR_DISC] && wr_cacheline_edge
		|=> wr_disconnect)
		else $error("no disconnect at cache line");
	a_wdisc_4k: assert property (wr_addr[BFC_WRITE_DISC_4K_MASK - 1:0] == '0
		|=> wr_disconnect)
		else $error("no disconnect at 4KB boundary");
	a_srst_follow: assert property (st_r.st == BFC_RUN
		&& st_r.bctl[BFC_BIT_SEC_RESET - 16] |=> !downstream_reset_n)
		else $error("secondary reset bit not driving reset");
endmodule

// ===== hdl/bfc_pkg.sv
// bfc_pkg: constants and types for the bridge forwarding control block
// assumes: a single 20 MHz configuration clock domain
package bfc_pkg;
	// ----------------------------------------
	// configuration offsets (dword-aligned byte addresses)
	// ----------------------------------------
	localparam logic [7:0] BFC_OFS_BRIDGE_CTRL = 8'h3C;
	localparam logic [7:0] BFC_OFS_CHIP_CTRL = 8'h40;
	localparam logic [7:0] BFC_OFS_CMD = 8'h04;
	// ----------------------------------------
	// bridge control field positions (in the 0x3C dword)
	// ----------------------------------------
	localparam int BFC_BIT_PARITY_RESP = 16;
	localparam int BFC_BIT_SERR_FWD = 17;
	localparam int BFC_BIT_ALIAS = 18;
	localparam int BFC_BIT_LEGACY_DISP = 19;
	localparam int BFC_BIT_SEC_RESET = 22;
	// ----------------------------------------
	// command register field positions
	// ----------------------------------------
	localparam int BFC_BIT_IO_EN = 0;
	localparam int BFC_BIT_MEM_EN = 1;
	localparam int BFC_BIT_SERR_DRV = 8;
	// ----------------------------------------
	// chip control field positions (in the 0x40 dword)
	// ----------------------------------------
	localparam int BFC_BIT_WR_DISC = 1;
	localparam int BFC_BIT_PREF_DIS = 4;
	localparam int BFC_BIT_CHIP_RST = 8;
	localparam logic [15:0] BFC_CHIP_CTRL_RST = 16'h0000;
	localparam logic [15:0] BFC_CHIP_CTRL_RMASK = 16'h0112;
	localparam logic [15:0] BFC_CMD_RST = 16'h0000;
	// ----------------------------------------
	// legacy display decode
	// ----------------------------------------
	localparam logic [31:0] BFC_VGA_MEM_LO = 32'h000A0000;
	localparam logic [31:0] BFC_VGA_MEM_HI = 32'h000BFFFF;
	localparam logic [9:0] BFC_VGA_IO_A_LO = 10'h3B0;
	localparam logic [9:0] BFC_VGA_IO_A_HI = 10'h3BB;
	localparam logic [9:0] BFC_VGA_IO_B_LO = 10'h0C0;
	localparam logic [9:0] BFC_VGA_IO_B_HI = 10'h3DF;
	// alias filter: offsets 0x100..0x3FF of each 1KB block, first 64KB only on the primary side
	localparam logic [9:0] BFC_ALIAS_LO = 10'h100;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int BFC_CLK_NS = 50;
	localparam int BFC_CHIP_RST_NS = 400;
	localparam int BFC_CHIP_RST_CYC = (BFC_CHIP_RST_NS + BFC_CLK_NS - 1) / BFC_CLK_NS;
	localparam int BFC_WRITE_DISC_4K_MASK = 12;
	// config cycle kinds
	typedef enum logic [1:0] {BFC_ACC_NONE, BFC_ACC_RD, BFC_ACC_WR} bfc_acc_t;
endpackage

// ===== hdl/bfc_decode.sv
// bfc_decode: combinational address claim logic for primary and secondary buses
// assumes: window and control inputs are registered in the same clock domain
module bfc_decode
	import bfc_pkg::*;
(
	input wire logic [31:0] addr,
	input wire logic is_io,
	input wire logic is_mem,
	input wire logic from_primary,
	input wire logic legacy_display_en,
	input wire logic legacy_io_alias_filter,
	input wire logic io_space_en,
	input wire logic mem_space_en,
	input wire logic [31:0] io_base,
	input wire logic [31:0] io_limit,
	output logic claim
);
	logic vga_mem;
	logic vga_io;
	logic in_win;
	logic alias_hit;
	logic vga_act;

	always_comb
	begin
		vga_mem = is_mem && addr >= BFC_VGA_MEM_LO && addr <= BFC_VGA_MEM_HI;
		vga_io = is_io && addr[31:16] == 16'h0000
			&& ((addr[9:0] >= BFC_VGA_IO_A_LO && addr[9:0] <= BFC_VGA_IO_A_HI)
			|| (addr[9:0] >= BFC_VGA_IO_B_LO && addr[9:0] <= BFC_VGA_IO_B_HI));
		in_win = is_io && addr >= io_base && addr <= io_limit;
		alias_hit = addr[9:0] >= BFC_ALIAS_LO;
		// legacy forwarding needs both space enables
		vga_act = legacy_display_en && io_space_en && mem_space_en;
		claim = 1'b0;
		if (from_primary)
		begin
			if (vga_act && (vga_mem || vga_io))
				claim = 1'b1;
			else if (in_win)
				claim = !(legacy_io_alias_filter && addr[31:16] == 16'h0000
					&& alias_hit);
		end
		else
		begin
			// secondary: legacy display traffic is never claimed while enabled
			if (vga_act && (vga_mem || vga_io))
				claim = 1'b0;
			else if (is_io && legacy_io_alias_filter && alias_hit)
				claim = 1'b1;
		end
	end
endmodule

// ===== verif/bfc_far_model.sv
// bfc_far_model: secondary bus agent that raises error events on command
// assumes: commands change just after the rising edge of clk_sys
module bfc_far_model
(
	input wire logic clk_sys,
	input wire logic downstream_reset_n,
	input wire logic [2:0] ev_cmd,
	output logic downstream_system_error_n,
	output logic sec_data_parity_err,
	output logic sec_addr_parity_err
);
	timeunit 1ns;
	timeprecision 1ns;
	// agents stay quiet while the secondary bus is held in reset
	always @(posedge clk_sys)
	begin
		downstream_system_error_n <= !(ev_cmd[0] && downstream_reset_n);
		sec_data_parity_err <= ev_cmd[1] && downstream_reset_n;
		sec_addr_parity_err <= ev_cmd[2] && downstream_reset_n;
	end
endmodule

// ===== verif/tb_bfc_top.sv
// tb_bfc_top: self-checking bench for the forwarding control block
// assumes: bfc_pkg and the design compiled first, far model beside it
module tb_bfc_top
	import bfc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic cfg_rd = 1'b0;
	logic cfg_wr = 1'b0;
	logic [7:0] cfg_addr = 8'h00;
	logic [3:0] be_n = 4'hF;
	logic [31:0] cfg_wdata = 32'h0, io_base = 32'h00002000, io_limit = 32'h00002FFF;
	logic [31:0] txn_addr = 32'h0, wr_addr = 32'h0, cfg_rdata, q;
	logic txn_io = 1'b0, txn_mem = 1'b0, txn_primary = 1'b0, rd_plain = 1'b0;
	logic wr_cacheline_edge = 1'b0, wr_queue_full = 1'b0, sec_status_clr = 1'b0;
	logic [2:0] ev_cmd = 3'h0;
	logic cfg_ack, txn_claim, upstream_system_error_n, downstream_parity_error_n;
	logic sec_parity_reported, rd_prefetch, rd_fwd_byte_en, rd_disc_first, wr_disconnect;
	logic downstream_reset_n, chip_reset_busy, dn_serr_n, dpe, ape;
	int mismatches = 0;
	int tests_run = 0;
	// ----------------------------------------
	// design and far side
	// ----------------------------------------
	bfc_top #(.CHIP_RST_CYC(2)) bfc_top_i (.clk_sys(clk_sys), .resetn(resetn),
		.cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .upstream_cmd_byte_en_n(be_n),
		.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .io_base(io_base),
		.io_limit(io_limit), .txn_addr(txn_addr), .txn_io(txn_io), .txn_mem(txn_mem),
		.txn_primary(txn_primary), .txn_claim(txn_claim), .downstream_system_error_n(dn_serr_n),
		.sec_data_parity_err(dpe), .sec_addr_parity_err(ape), .sec_status_clr(sec_status_clr),
		.upstream_system_error_n(upstream_system_error_n),
		.downstream_parity_error_n(downstream_parity_error_n),
		.sec_parity_reported(sec_parity_reported), .rd_plain(rd_plain),
		.wr_cacheline_edge(wr_cacheline_edge), .wr_queue_full(wr_queue_full), .wr_addr(wr_addr),
		.rd_prefetch(rd_prefetch), .rd_fwd_byte_en(rd_fwd_byte_en), .rd_disc_first(rd_disc_first),
		.wr_disconnect(wr_disconnect), .downstream_reset_n(downstream_reset_n),
		.chip_reset_busy(chip_reset_busy));
	bfc_far_model bfc_far_model_i (.clk_sys(clk_sys), .downstream_reset_n(downstream_reset_n),
		.ev_cmd(ev_cmd), .downstream_system_error_n(dn_serr_n), .sec_data_parity_err(dpe),
		.sec_addr_parity_err(ape));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic chb(input string nm, input logic seen, input logic exp);
		chk(nm, {31'h0, seen}, {31'h0, exp});
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// one config cycle; read data lands in q
	task automatic cfg(input int wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] b);
		int n;
		n = 0;
		@(posedge clk_sys);
		cfg_wr <= (wr != 0);
		cfg_rd <= (wr == 0);
		cfg_addr <= a;
		cfg_wdata <= d;
		be_n <= b;
		@(posedge clk_sys);
		cfg_wr <= 1'b0;
		cfg_rd <= 1'b0;
		#1;
		while (cfg_ack !== 1'b1 && n < 8)
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chk("cfg_ack", {31'h0, cfg_ack}, 32'h1);
		q = cfg_rdata;
	endtask
	task automatic dec(input logic [31:0] a, input int io, input int prim, input int e);
		@(posedge clk_sys);
		txn_addr <= a;
		txn_io <= (io != 0);
		txn_mem <= (io == 0);
		txn_primary <= (prim != 0);
		tick(1);
		chb("txn_claim", txn_claim, e != 0);
	endtask
	task automatic far(input logic [2:0] c);
		@(posedge clk_sys);
		ev_cmd <= c;
	endtask
	// ----------------------------------------
	// clock, watchdog, tests
	// ----------------------------------------
	initial
	begin
		forever #25 clk_sys = !clk_sys;
	end
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		mismatches++;
		final_report();
	end
	initial
	begin
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		cfg(0, BFC_OFS_CHIP_CTRL, 32'h0, 4'hF);
		chk("chip_ctrl", q, 32'h0);
		cfg(1, BFC_OFS_CHIP_CTRL, 32'h000000FF, 4'hC);
		cfg(0, BFC_OFS_CHIP_CTRL, 32'h0, 4'hF);
		chk("chip_ctrl", q, 32'h00000012);
		cfg(1, BFC_OFS_BRIDGE_CTRL, 32'h00FF0000, 4'hF);
		cfg(0, BFC_OFS_BRIDGE_CTRL, 32'h0, 4'hF);
		chk("bridge_ctrl", q, 32'h0);
		cfg(0, 8'h80, 32'h0, 4'hF);
		chk("unmapped", q, 32'h0);
		$display("test registers done");
		// read and write policy, both settings of each bit
		cfg(1, BFC_OFS_CHIP_CTRL, 32'h0, 4'hC);
		@(posedge clk_sys);
		rd_plain <= 1'b1;
		wr_cacheline_edge <= 1'b1;
		wr_addr <= 32'h00001040;
		tick(1);
		chb("rd_prefetch", rd_prefetch, 1'b1);
		chb("rd_fwd_byte_en", rd_fwd_byte_en, 1'b0);
		chb("rd_disc_first", rd_disc_first, 1'b0);
		chb("wr_disconnect", wr_disconnect, 1'b0);
		cfg(1, BFC_OFS_CHIP_CTRL, 32'h00000012, 4'hC);
		tick(1);
		chb("rd_prefetch", rd_prefetch, 1'b0);
		chb("rd_fwd_byte_en", rd_fwd_byte_en, 1'b1);
		chb("rd_disc_first", rd_disc_first, 1'b1);
		chb("wr_disconnect", wr_disconnect, 1'b1);
		@(posedge clk_sys);
		rd_plain <= 1'b0;
		wr_cacheline_edge <= 1'b0;
		wr_queue_full <= 1'b1;
		tick(1);
		chb("rd_prefetch", rd_prefetch, 1'b1);
		chb("wr_disconnect", wr_disconnect, 1'b1);
		@(posedge clk_sys);
		wr_queue_full <= 1'b0;
		wr_addr <= 32'h00002000;
		tick(1);
		chb("wr_disconnect", wr_disconnect, 1'b1);
		$display("test policy done");
		// address decode
		cfg(1, BFC_OFS_CMD, 32'h00000103, 4'hC);
		cfg(1, BFC_OFS_BRIDGE_CTRL, 32'h00080000, 4'hB);
		dec(32'h000A0000, 0, 1, 1);
		dec(32'h000BFFFF, 0, 1, 1);
		dec(32'h000C0000, 0, 1, 0);
		dec(32'h0000FFBB, 1, 1, 1);
		dec(32'h000000C0, 1, 1, 1);
		dec(32'h000003E0, 1, 1, 0);
		dec(32'h000100C0, 1, 1, 0);
		dec(32'h000A0000, 0, 0, 0);
		dec(32'h000003B0, 1, 0, 0);
		cfg(1, BFC_OFS_CMD, 32'h00000101, 4'hC);
		dec(32'h000A0000, 0, 1, 0);
		cfg(1, BFC_OFS_CMD, 32'h00000103, 4'hC);
		cfg(1, BFC_OFS_BRIDGE_CTRL, 32'h0, 4'hB);
		dec(32'h000A0000, 0, 1, 0);
		dec(32'h00002100, 1, 1, 1);
		dec(32'h00003000, 1, 1, 0);
		cfg(1, BFC_OFS_BRIDGE_CTRL, 32'h00040000, 4'hB);
		dec(32'h00002100, 1, 1, 0);
		dec(32'h00002010, 1, 1, 1);
		dec(32'h00000100, 1, 0, 1);
		$display("test decode done");
		// error forwarding and parity response
		cfg(1, BFC_OFS_BRIDGE_CTRL, 32'h00020000, 4'hB);
		far(3'h1);
		tick(5);
		chb("upstream_serr_n", upstream_system_error_n, 1'b0);
		far(3'h0);
		cfg(1, BFC_OFS_BRIDGE_CTRL, 32'h0, 4'hB);
		far(3'h1);
		tick(5);
		chb("upstream_serr_n", upstream_system_error_n, 1'b1);
		far(3'h0);
		cfg(1, BFC_OFS_BRIDGE_CTRL, 32'h00020000, 4'hB);
		far(3'h4);
		far(3'h0);
		tick(2);
		chb("upstream_serr_n", upstream_system_error_n, 1'b1);
		far(3'h2);
		far(3'h0);
		tick(1);
		chb("parity_err_n", downstream_parity_error_n, 1'b1);
		chb("parity_reported", sec_parity_reported, 1'b0);
		cfg(1, BFC_OFS_BRIDGE_CTRL, 32'h00010000, 4'hB);
		far(3'h2);
		far(3'h0);
		tick(1);
		chb("parity_err_n", downstream_parity_error_n, 1'b0);
		tick(2);
		chb("parity_reported", sec_parity_reported, 1'b1);
		far(3'h4);
		far(3'h0);
		tick(1);
		chb("upstream_serr_n", upstream_system_error_n, 1'b0);
		far(3'h2);
		far(3'h0);
		sec_status_clr <= 1'b1;
		tick(1);
		chb("parity_reported", sec_parity_reported, 1'b1);
		@(posedge clk_sys);
		sec_status_clr <= 1'b0;
		#1;
		chb("parity_reported", sec_parity_reported, 1'b0);
		far(3'h2);
		far(3'h0);
		tick(1);
		chb("parity_reported", sec_parity_reported, 1'b1);
		$display("test errors done");
		// whole-chip reset, then secondary reset alone
		cfg(1, BFC_OFS_CHIP_CTRL, 32'h00000100, 4'hC);
		chb("chip_reset_busy", chip_reset_busy, 1'b1);
		tick(1);
		chb("downstream_reset_n", downstream_reset_n, 1'b0);
		tick(4);
		chb("chip_reset_busy", chip_reset_busy, 1'b0);
		chb("parity_reported", sec_parity_reported, 1'b0);
		cfg(0, BFC_OFS_CHIP_CTRL, 32'h0, 4'hF);
		chk("chip_ctrl", q, 32'h0);
		cfg(0, BFC_OFS_BRIDGE_CTRL, 32'h0, 4'hF);
		chk("bridge_ctrl", q, 32'h00400000);
		chb("downstream_reset_n", downstream_reset_n, 1'b0);
		cfg(1, BFC_OFS_CMD, 32'h00000103, 4'hC);
		cfg(1, BFC_OFS_BRIDGE_CTRL, 32'h00480000, 4'hB);
		cfg(0, BFC_OFS_CMD, 32'h0, 4'hF);
		chk("cmd", q, 32'h00000103);
		cfg(0, BFC_OFS_BRIDGE_CTRL, 32'h0, 4'hF);
		chk("bridge_ctrl", q, 32'h00480000);
		cfg(1, BFC_OFS_BRIDGE_CTRL, 32'h00080000, 4'hB);
		tick(1);
		chb("downstream_reset_n", downstream_reset_n, 1'b1);
		$display("test chip reset done");
		final_report();
	end
endmodule
